// ### clock_gen_control_bank.sv
// Serially programmed control bank of the clock generator with output run gating
// Functional notes
// - Bit seven picks strap or software frequency
// - Three independent per-group spread enables, reset off
// - Four-bit processor select; low bits from straps
// - Byte one: single-ended output enables, reset on
// - Graphics pair enables, reset enabled
// - Second request pin may own reference pairs two, one
// - Master reference enables override request pins
// - First request pin may own pairs five to three
// - Third request pin may own graphics pairs, pair zero
// - Three-bit drive level, reset gives 0.8V
// - Four-bit reference frequency select, reset zero
// - Fixed read-only device identifier
// - Block write: index, count, data bytes acknowledged
// - Block read: count then consecutive bytes
`include "clock_gen_params.svh"
module clock_gen_control_bank
  import clock_gen_pkg::*;
#(
  parameter logic [7:0] READ_COUNT = `CG_BLOCK_BYTES,
  parameter logic [7:0] DEVICE_ID  = `CG_RST_DEVICE_ID  // Arbitrary value
)
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       smb_clk,
  input  wire logic       smb_data_in,
  output logic            smb_data_out,
  output logic            smb_data_oe,
  input  wire logic [2:0] strap_freq_select,
  input  wire logic       clock_request_first_n,
  input  wire logic       clock_request_second_n,
  input  wire logic       clock_request_third_n,
  output logic            freq_source_select,
  output logic [3:0]      processor_freq_select,
  output logic            graphics_spread_enable,
  output logic            periph_ref_spread_enable,
  output logic            processor_spread_enable,
  output logic [7:0]      single_ended_run,
  output logic [1:0]      graphics_pair_run,
  output logic [5:0]      periph_ref_pair_run,
  output logic [2:0]      drive_level_select,
  output logic [3:0]      periph_ref_freq_select
);
  byte_link_if link ();

  write_phase_t  phase;
  logic [7:0]    index;
  logic [7:0]    count_left;
  logic          rd_first;
  logic          wr_commit;
  logic          strap_taken;
  logic [2:0]    strap_latched;
  logic [7:0]    spread_and_cpu_freq_select;
  logic [7:0]    single_ended_output_enables;
  logic [7:0]    graphics_enable_and_request_b_map;
  logic [7:0]    reference_pair_master_enables;
  logic [7:0]    request_a_c_assignment;
  logic [7:0]    voltage_and_reference_freq_select;

  smbus_target_engine u_engine (
    .ref_clk     (ref_clk),
    .nrst        (nrst),
    .ce          (ce),
    .smb_clk     (smb_clk),
    .smb_data_in (smb_data_in),
    .smb_data_oe (smb_data_oe),
    .link        (link.engine)
  );

  // Open-drain line: only ever pulled low
  assign smb_data_out = 1'b0;

  // Reserved bits keep their fixed value whatever the host writes
  function automatic logic [7:0] merge(input logic [7:0] old_val,
                                       input logic [7:0] new_val,
                                       input logic [7:0] wmask);
    merge = (old_val & ~wmask) | (new_val & wmask);
  endfunction : merge

  // Owned outputs wait for their request
  function automatic logic gate(input logic en,
                                input logic owned,
                                input logic req_n);
    gate = en & (~owned | ~req_n);
  endfunction : gate

  // Unused indices read zero
  // Identifier is fixed, writes miss it
  function automatic logic [7:0] read_mux(input logic [7:0] idx);
    unique case (idx)
      `CG_IDX_SPREAD:    read_mux = spread_and_cpu_freq_select;
      `CG_IDX_SE_EN:     read_mux = single_ended_output_enables;
      `CG_IDX_GFX_REQB:  read_mux = graphics_enable_and_request_b_map;
      `CG_IDX_REF_EN:    read_mux = reference_pair_master_enables;
      `CG_IDX_REQ_AC:    read_mux = request_a_c_assignment;
      `CG_IDX_VOLT_FREQ: read_mux = voltage_and_reference_freq_select;
      `CG_IDX_DEVICE_ID: read_mux = DEVICE_ID;
      default:           read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // Surplus bytes are acked, then dropped
  assign wr_commit = link.wr_strobe && phase == ph_data
                     && count_left != 8'h00;

  // Block framing: a start always re-arms the index phase, so a repeated start reads from N
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase      <= ph_index;
      index      <= 8'h00;
      count_left <= 8'h00;
    end else if (ce) begin
      if (link.start_seen) begin
        phase <= ph_index;
      end else if (link.wr_strobe) begin
        unique case (phase)
          ph_index: begin
            index <= link.wr_byte;
            phase <= ph_count;
          end
          ph_count: begin
            count_left <= link.wr_byte;
            phase      <= ph_data;
          end
          ph_data: begin
            if (count_left != 8'h00) begin
              index      <= index + 8'h01;
              count_left <= count_left - 8'h01;
            end
          end
          default: begin
            phase <= ph_index;
          end
        endcase
      end else if (link.rd_req && !rd_first) begin
        // Count byte leaves the index alone
        index <= index + 8'h01;
      end
    end
  end

  // Read path: first byte of a read is the count, then bytes from the index onward
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_first     <= 1'b1;
      link.rd_byte <= 8'h00;
    end else if (ce) begin
      if (link.start_seen) begin
        rd_first <= 1'b1;
      end else if (link.rd_req) begin
        rd_first <= 1'b0;
        if (rd_first) begin
          link.rd_byte <= READ_COUNT;
        end else begin
          link.rd_byte <= read_mux(index);
        end
      end
    end
  end

  // Straps land once, on the first enabled edge after reset release
  // Own copy, so host writes cannot move it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strap_taken   <= 1'b0;
      strap_latched <= 3'h0;
    end else if (ce) begin
      strap_taken <= 1'b1;
      if (!strap_taken) begin
        strap_latched <= strap_freq_select;
      end
    end
  end

  // Host write beats the strap load
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      spread_and_cpu_freq_select <= `CG_RST_SPREAD;
    end else if (ce) begin
      if (wr_commit && index == `CG_IDX_SPREAD) begin
        spread_and_cpu_freq_select <= merge(spread_and_cpu_freq_select, link.wr_byte,
                                            `CG_WMASK_SPREAD);
      end else if (!strap_taken) begin
        spread_and_cpu_freq_select[`CG_STRAP_MSB:0] <= strap_freq_select;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      single_ended_output_enables <= `CG_RST_SE_EN;
    end else if (ce && wr_commit && index == `CG_IDX_SE_EN) begin
      single_ended_output_enables <= merge(single_ended_output_enables, link.wr_byte,
                                           `CG_WMASK_SE_EN);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      graphics_enable_and_request_b_map <= `CG_RST_GFX_REQB;
    end else if (ce && wr_commit && index == `CG_IDX_GFX_REQB) begin
      graphics_enable_and_request_b_map <= merge(graphics_enable_and_request_b_map,
                                                 link.wr_byte, `CG_WMASK_GFX_REQB);
    end
  end

  // Reserved bits 3 and 1 stay set
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reference_pair_master_enables <= `CG_RST_REF_EN;
    end else if (ce && wr_commit && index == `CG_IDX_REF_EN) begin
      reference_pair_master_enables <= merge(reference_pair_master_enables, link.wr_byte,
                                             `CG_WMASK_REF_EN);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      request_a_c_assignment <= `CG_RST_REQ_AC;
    end else if (ce && wr_commit && index == `CG_IDX_REQ_AC) begin
      request_a_c_assignment <= merge(request_a_c_assignment, link.wr_byte,
                                      `CG_WMASK_REQ_AC);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      voltage_and_reference_freq_select <= `CG_RST_VOLT_FREQ;
    end else if (ce && wr_commit && index == `CG_IDX_VOLT_FREQ) begin
      voltage_and_reference_freq_select <= merge(voltage_and_reference_freq_select,
                                                 link.wr_byte, `CG_WMASK_VOLT_FREQ);
    end
  end

  // Control outputs; processor select falls back to the latched straps while source is 0
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      freq_source_select       <= 1'b0;
      processor_freq_select    <= 4'h0;
      graphics_spread_enable   <= 1'b0;
      periph_ref_spread_enable <= 1'b0;
      processor_spread_enable  <= 1'b0;
      drive_level_select       <= 3'h5;
      periph_ref_freq_select   <= 4'h0;
    end else if (ce) begin
      freq_source_select <= spread_and_cpu_freq_select[`CG_BIT_FREQ_SOURCE];
      if (spread_and_cpu_freq_select[`CG_BIT_FREQ_SOURCE]) begin
        processor_freq_select <= spread_and_cpu_freq_select[`CG_FREQ_MSB:0];
      end else begin
        processor_freq_select <= {1'b0, strap_latched};
      end
      graphics_spread_enable   <= spread_and_cpu_freq_select[`CG_BIT_GFX_SPREAD];
      periph_ref_spread_enable <= spread_and_cpu_freq_select[`CG_BIT_REF_SPREAD];
      processor_spread_enable  <= spread_and_cpu_freq_select[`CG_BIT_CPU_SPREAD];
      drive_level_select       <=
        voltage_and_reference_freq_select[`CG_LEVEL_MSB:`CG_LEVEL_LSB];
      periph_ref_freq_select   <= voltage_and_reference_freq_select[`CG_FREQ_MSB:0];
    end
  end

  // Output run gating: master enable first, then the owning request pin if any
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // Run outputs start enabled
      single_ended_run    <= `CG_RST_SE_EN;
      graphics_pair_run   <= 2'h3;
      periph_ref_pair_run <= 6'h3f;
    end else if (ce) begin
      single_ended_run <= single_ended_output_enables;
      graphics_pair_run[1] <= gate(graphics_enable_and_request_b_map[`CG_BIT_GFX1_EN],
                                   request_a_c_assignment[`CG_BIT_C_OWNS_GFX1],
                                   clock_request_third_n);
      graphics_pair_run[0] <= gate(graphics_enable_and_request_b_map[`CG_BIT_GFX0_EN],
                                   request_a_c_assignment[`CG_BIT_C_OWNS_GFX0],
                                   clock_request_third_n);
      periph_ref_pair_run[5] <= gate(reference_pair_master_enables[`CG_BIT_REF5_EN],
                                     request_a_c_assignment[`CG_BIT_A_OWNS_REF5],
                                     clock_request_first_n);
      periph_ref_pair_run[4] <= gate(reference_pair_master_enables[`CG_BIT_REF4_EN],
                                     request_a_c_assignment[`CG_BIT_A_OWNS_REF4],
                                     clock_request_first_n);
      periph_ref_pair_run[3] <= gate(reference_pair_master_enables[`CG_BIT_REF3_EN],
                                     request_a_c_assignment[`CG_BIT_A_OWNS_REF3],
                                     clock_request_first_n);
      periph_ref_pair_run[2] <= gate(reference_pair_master_enables[`CG_BIT_CRYSTAL_COPY_OUT_2_EN],
                                     graphics_enable_and_request_b_map[`CG_BIT_B_OWNS_CRYSTAL_COPY_OUT_2],
                                     clock_request_second_n);
      periph_ref_pair_run[1] <= gate(reference_pair_master_enables[`CG_BIT_CRYSTAL_COPY_OUT_1_EN],
                                     graphics_enable_and_request_b_map[`CG_BIT_B_OWNS_CRYSTAL_COPY_OUT_1],
                                     clock_request_second_n);
      periph_ref_pair_run[0] <= gate(reference_pair_master_enables[`CG_BIT_CRYSTAL_COPY_OUT_0_EN],
                                     request_a_c_assignment[`CG_BIT_C_OWNS_CRYSTAL_COPY_OUT_0],
                                     clock_request_third_n);
    end
  end
endmodule : clock_gen_control_bank

// ### clock_gen_params.svh
// Byte indices, field positions, masks, reset values and bus constants of the control bank
`ifndef CLOCK_GEN_PARAMS_SVH
`define CLOCK_GEN_PARAMS_SVH

`define CG_BYTE_W           8
`define CG_BIT_CNT_W        4
`define CG_BITS_PER_BYTE    4'h8
`define CG_TARGET_ADDR      7'h69
`define CG_RW_READ          1'b1

`define CG_IDX_SPREAD       8'h00
`define CG_IDX_SE_EN        8'h01
`define CG_IDX_GFX_REQB     8'h02
`define CG_IDX_REF_EN       8'h03
`define CG_IDX_REQ_AC       8'h04
`define CG_IDX_VOLT_FREQ    8'h05
`define CG_IDX_DEVICE_ID    8'h06
`define CG_BLOCK_BYTES      8'h07

`define CG_RST_SPREAD       8'h00
`define CG_RST_SE_EN        8'hff
`define CG_RST_GFX_REQB     8'h30
`define CG_RST_REF_EN       8'hff
`define CG_RST_REQ_AC       8'h00
`define CG_RST_VOLT_FREQ    8'ha0
`define CG_RST_DEVICE_ID    8'h5a

`define CG_WMASK_SPREAD     8'hff
`define CG_WMASK_SE_EN      8'hff
`define CG_WMASK_GFX_REQB   8'h3a
`define CG_WMASK_REF_EN     8'hf5
`define CG_WMASK_REQ_AC     8'he7
`define CG_WMASK_VOLT_FREQ  8'hef

`define CG_BIT_FREQ_SOURCE  7
`define CG_BIT_GFX_SPREAD   6
`define CG_BIT_REF_SPREAD   5
`define CG_BIT_CPU_SPREAD   4
`define CG_BIT_GFX1_EN      5
`define CG_BIT_GFX0_EN      4
`define CG_BIT_B_OWNS_CRYSTAL_COPY_OUT_2  3
`define CG_BIT_B_OWNS_CRYSTAL_COPY_OUT_1  1
`define CG_BIT_REF5_EN      7
`define CG_BIT_REF4_EN      6
`define CG_BIT_REF3_EN      5
`define CG_BIT_CRYSTAL_COPY_OUT_2_EN      4
`define CG_BIT_CRYSTAL_COPY_OUT_1_EN      2
`define CG_BIT_CRYSTAL_COPY_OUT_0_EN      0
`define CG_BIT_A_OWNS_REF5  7
`define CG_BIT_A_OWNS_REF4  6
`define CG_BIT_A_OWNS_REF3  5
`define CG_BIT_C_OWNS_GFX1  2
`define CG_BIT_C_OWNS_GFX0  1
`define CG_BIT_C_OWNS_CRYSTAL_COPY_OUT_0  0
`define CG_LEVEL_MSB        7
`define CG_LEVEL_LSB        5
`define CG_FREQ_MSB         3
`define CG_STRAP_MSB        2

`endif

// ### clock_gen_pkg.sv
// Types shared by the serial engine and the control bank
package clock_gen_pkg;
  typedef enum logic [2:0] {st_idle, st_addr, st_ack_out, st_wr, st_rd, st_ack_in} link_state_t;
  typedef enum logic [1:0] {ph_index, ph_count, ph_data} write_phase_t;
endpackage : clock_gen_pkg

// ### byte_link_if.sv
// Byte-level carrier between the serial target engine and the control bank
interface byte_link_if;
  logic       start_seen;
  logic       wr_strobe;
  logic [7:0] wr_byte;
  logic       rd_req;
  logic [7:0] rd_byte;
  modport engine (output start_seen, output wr_strobe, output wr_byte, output rd_req,
                  input rd_byte);
  modport bank   (input start_seen, input wr_strobe, input wr_byte, input rd_req,
                  output rd_byte);
endinterface : byte_link_if

// ### smbus_target_engine.sv
// Bit-level serial target: start/stop detection, address match, byte shift and acknowledge
`include "clock_gen_params.svh"
module smbus_target_engine
  import clock_gen_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  nrst,
  input  wire logic  ce,
  input  wire logic  smb_clk,
  input  wire logic  smb_data_in,
  output logic       smb_data_oe,
  byte_link_if.engine link
);
  link_state_t                  state;
  logic [`CG_BYTE_W-1:0]        shreg;
  logic [`CG_BIT_CNT_W-1:0]     cnt;
  logic                         is_read;
  logic                         got_ack;
  logic                         clk_q;
  logic                         data_q;
  logic                         rise;
  logic                         fall;
  logic                         start_det;
  logic                         stop_det;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clk_q  <= 1'b1;
      data_q <= 1'b1;
    end else if (ce) begin
      clk_q  <= smb_clk;
      data_q <= smb_data_in;
    end
  end

  assign rise      = smb_clk & ~clk_q;
  assign fall      = ~smb_clk & clk_q;
  assign start_det = smb_clk & clk_q & data_q & ~smb_data_in;
  assign stop_det  = smb_clk & clk_q & ~data_q & smb_data_in;

  // Drive is set only on falling edges; a start or stop releases it, the one change made while clock is high
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state       <= st_idle;
      shreg       <= '0;
      cnt         <= '0;
      is_read     <= 1'b0;
      got_ack     <= 1'b0;
      smb_data_oe <= 1'b0;
    end else if (ce) begin
      if (stop_det) begin
        state       <= st_idle;
        smb_data_oe <= 1'b0;
      end else if (start_det) begin
        state       <= st_addr;
        cnt         <= '0;
        smb_data_oe <= 1'b0;
      end else if (rise) begin
        if (state == st_addr || state == st_wr) begin
          shreg <= {shreg[`CG_BYTE_W-2:0], smb_data_in};
          cnt   <= cnt + 1'b1;
        end else if (state == st_rd) begin
          cnt <= cnt + 1'b1;
        end else if (state == st_ack_in) begin
          got_ack <= ~smb_data_in;
        end
      end else if (fall) begin
        unique case (state)
          st_idle: begin
            smb_data_oe <= 1'b0;
          end
          st_addr: begin
            if (cnt == `CG_BITS_PER_BYTE) begin
              if (shreg[`CG_BYTE_W-1:1] == `CG_TARGET_ADDR) begin
                state       <= st_ack_out;
                is_read     <= shreg[0] == `CG_RW_READ;
                smb_data_oe <= 1'b1;
              end else begin
                state <= st_idle;
              end
            end
          end
          st_wr: begin
            if (cnt == `CG_BITS_PER_BYTE) begin
              state       <= st_ack_out;
              smb_data_oe <= 1'b1;
            end
          end
          st_ack_out: begin
            cnt <= '0;
            if (is_read) begin
              state       <= st_rd;
              shreg       <= {link.rd_byte[`CG_BYTE_W-2:0], 1'b0};
              smb_data_oe <= ~link.rd_byte[`CG_BYTE_W-1];
            end else begin
              state       <= st_wr;
              smb_data_oe <= 1'b0;
            end
          end
          st_rd: begin
            if (cnt == `CG_BITS_PER_BYTE) begin
              state       <= st_ack_in;
              smb_data_oe <= 1'b0;
            end else begin
              shreg       <= {shreg[`CG_BYTE_W-2:0], 1'b0};
              smb_data_oe <= ~shreg[`CG_BYTE_W-1];
            end
          end
          st_ack_in: begin
            cnt <= '0;
            if (got_ack) begin
              state       <= st_rd;
              shreg       <= {link.rd_byte[`CG_BYTE_W-2:0], 1'b0};
              smb_data_oe <= ~link.rd_byte[`CG_BYTE_W-1];
            end else begin
              state <= st_idle;
            end
          end
        endcase
      end
    end
  end

  // Byte events for the bank; rd_req leaves at least one bus half period to prepare rd_byte
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      link.start_seen <= 1'b0;
      link.wr_strobe  <= 1'b0;
      link.wr_byte    <= '0;
      link.rd_req     <= 1'b0;
    end else if (ce) begin
      link.start_seen <= start_det;
      link.wr_strobe  <= fall && !start_det && !stop_det && state == st_wr
                         && cnt == `CG_BITS_PER_BYTE;
      link.rd_req     <= (fall && !start_det && !stop_det && state == st_addr
                          && cnt == `CG_BITS_PER_BYTE
                          && shreg[`CG_BYTE_W-1:1] == `CG_TARGET_ADDR
                          && shreg[0] == `CG_RW_READ)
                         || (rise && !start_det && !stop_det && state == st_ack_in
                             && !smb_data_in);
      if (fall && state == st_wr && cnt == `CG_BITS_PER_BYTE) begin
        link.wr_byte <= shreg;
      end
    end
  end
endmodule : smbus_target_engine

// ### clock_gen_bank_monitor.sv
// Port-level assertions for the clock generator control bank
module clock_gen_bank_monitor (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       smb_clk,
  input wire logic       smb_data_out,
  input wire logic       smb_data_oe,
  input wire logic       clock_request_first_n,
  input wire logic       clock_request_second_n,
  input wire logic       clock_request_third_n,
  input wire logic       freq_source_select,
  input wire logic [3:0] processor_freq_select,
  input wire logic [1:0] graphics_pair_run,
  input wire logic [5:0] periph_ref_pair_run
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // One whole bus clock period: a rise then a fall
  sequence low_high_low;
    ##[1:20] $rose(smb_clk) ##[1:20] $fell(smb_clk);
  endsequence
  oe_low_change_a: assert property ($changed(smb_data_oe) |-> !smb_clk)
    else $error("data drive changed while bus clock high");
  data_out_low_a: assert property (smb_data_out == 1'b0)
    else $error("open-drain data output not low");
  ack_hold_a: assert property ($rose(smb_data_oe) |-> smb_data_oe throughout low_high_low)
    else $error("data drive released inside its bit");
  cpu_sel_msb_a: assert property (!freq_source_select |-> !processor_freq_select[3])
    else $error("processor select top bit set under strap control");
  strap_hold_a: assert property ($past(nrst, 3) && !freq_source_select
    && !$past(freq_source_select) |-> $stable(processor_freq_select))
    else $error("processor select moved under strap control");
  // Bus writes land while the bus clock is low, so a change with it high is request-driven
  ref5_rise_a: assert property ($rose(periph_ref_pair_run[5]) && smb_clk |->
    !$past(clock_request_first_n)) else $error("pair five started without request");
  ref5_fall_a: assert property ($fell(periph_ref_pair_run[5]) && smb_clk |->
    $past(clock_request_first_n)) else $error("pair five stopped while requested");
  gfx1_rise_a: assert property ($rose(graphics_pair_run[1]) && smb_clk |->
    !$past(clock_request_third_n)) else $error("graphics pair started without request");
  crystal_copy_out_2_rise_a: assert property ($rose(periph_ref_pair_run[2]) && smb_clk |->
    !$past(clock_request_second_n)) else $error("pair two started without request");
endmodule : clock_gen_bank_monitor

bind clock_gen_control_bank clock_gen_bank_monitor u_mon (.ref_clk, .nrst, .smb_clk,
  .smb_data_out, .smb_data_oe, .clock_request_first_n,
  .clock_request_second_n, .clock_request_third_n, .freq_source_select,
  .processor_freq_select, .graphics_pair_run, .periph_ref_pair_run);

// ### smbus_host_model.sv
// Behavioural board-side bus host for the control bank
module smbus_host_model (
  input  wire logic ref_clk,
  input  wire logic smb_data_oe,
  output logic      smb_clk,
  output logic      smb_data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sda = 1'b1;
  initial smb_clk = 1'b1;
  // Pulled-up wire, low whenever either side pulls
  assign smb_data_in = sda & ~smb_data_oe;
  // Five cycles per half keeps above the four-cycle minimum
  task automatic half;
    repeat (5) @(posedge ref_clk);
  endtask : half
  task automatic bit_io(input logic b, output logic r);
    @(posedge ref_clk);
    sda <= b;
    half();
    smb_clk <= 1'b1;
    half();
    r = smb_data_in;
    smb_clk <= 1'b0;
  endtask : bit_io
  task automatic start;
    @(posedge ref_clk);
    sda <= 1'b1;
    half();
    smb_clk <= 1'b1;
    half();
    sda <= 1'b0;
    half();
    smb_clk <= 1'b0;
  endtask : start
  task automatic stop;
    @(posedge ref_clk);
    sda <= 1'b0;
    half();
    smb_clk <= 1'b1;
    half();
    sda <= 1'b1;
    half();
  endtask : stop
  task automatic byte_io(input logic [7:0] b, input logic a_out, output logic [7:0] r,
                         output logic a_in);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(a_out, a_in);
  endtask : byte_io
  task automatic write_block(input logic [7:0] adr, input logic [7:0] idx,
                             input logic [7:0] d[$], output logic nack);
    logic [7:0] r;
    logic       a;
    start();
    byte_io(adr, 1'b1, r, nack);
    byte_io(idx, 1'b1, r, a);
    byte_io(8'(d.size()), 1'b1, r, a);
    foreach (d[i]) byte_io(d[i], 1'b1, r, a);
    stop();
  endtask : write_block
  task automatic read_block(input logic [7:0] idx, input int n, output logic [7:0] q[$]);
    logic [7:0] r;
    logic       a;
    q = {};
    start();
    byte_io(8'hd2, 1'b1, r, a);
    byte_io(idx, 1'b1, r, a);
    start();
    byte_io(8'hd3, 1'b1, r, a);
    for (int i = 0; i <= n; i++) begin
      byte_io(8'hff, i == n, r, a); // Host ends with a not-acknowledge
      q.push_back(r);
    end
    stop();
  endtask : read_block
endmodule : smbus_host_model

// ### clock_gen_control_bank_test.sv
// Self-checking bench for the clock generator control bank
module clock_gen_control_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] idx; logic [7:0] wdata; logic [7:0] exp;} row_t;
  logic       ref_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       smb_clk, smb_data_in, smb_data_oe, smb_data_out;
  logic [2:0] strap = 3'b101;
  logic [2:0] req_n = 3'b111;
  logic       src, gss, rss, pss, nack;
  logic [3:0] pfs, rfs;
  logic [7:0] se_run, q[$], wq[$];
  logic [1:0] gfx_run;
  logic [5:0] ref_run;
  logic [2:0] lvl;
  int         n_fail = 0;
  int         n_checks = 0;
  // Identifier value is arbitrary
  localparam logic [7:0] ID = 8'h3c;
  row_t rows[7] = '{'{8'h00, 8'hff, 8'hff}, '{8'h01, 8'h5a, 8'h5a}, '{8'h02, 8'hff, 8'h3a},
                    '{8'h03, 8'h00, 8'h0a}, '{8'h04, 8'hff, 8'he7}, '{8'h05, 8'hff, 8'hef},
                    '{8'h06, 8'h00, ID}};
  logic [7:0] rst_exp[7] = '{8'h05, 8'hff, 8'h30, 8'hff, 8'h00, 8'ha0, ID};
  logic [2:0] rq[4] = '{3'b111, 3'b011, 3'b101, 3'b110};
  logic [7:0] gate_exp[4] = '{8'h00, 8'h38, 8'h06, 8'hc1};
  always #50 ref_clk = ~ref_clk;
  smbus_host_model u_host (.ref_clk(ref_clk), .smb_data_oe(smb_data_oe), .smb_clk(smb_clk),
                           .smb_data_in(smb_data_in));
  clock_gen_control_bank #(.DEVICE_ID(ID)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1),
    .smb_clk(smb_clk), .smb_data_in(smb_data_in), .smb_data_out(smb_data_out),
    .smb_data_oe(smb_data_oe), .strap_freq_select(strap), .clock_request_first_n(req_n[2]),
    .clock_request_second_n(req_n[1]), .clock_request_third_n(req_n[0]),
    .freq_source_select(src), .processor_freq_select(pfs), .graphics_spread_enable(gss),
    .periph_ref_spread_enable(rss), .processor_spread_enable(pss), .single_ended_run(se_run),
    .graphics_pair_run(gfx_run), .periph_ref_pair_run(ref_run), .drive_level_select(lvl),
    .periph_ref_freq_select(rfs));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check("level", {5'h00, lvl}, 8'h05);
    check("proc select", {4'h0, pfs}, 8'h05);
    strap <= 3'b010;
    u_host.read_block(8'h00, 7, q);
    check("latched select", {4'h0, pfs}, 8'h05);
    check("count", q[0], 8'h07);
    for (int i = 0; i < 7; i++) check("reset byte", q[i+1], rst_exp[i]);
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      wq = {rows[i].wdata};
      u_host.write_block(8'hd2, rows[i].idx, wq, nack);
      check("ack", {7'h00, nack}, 8'h00);
      u_host.read_block(rows[i].idx, 1, q);
      check("readback", q[1], rows[i].exp);
    end
    check("freq group", {src, gss, rss, pss, pfs}, 8'hff);
    check("outputs", se_run, 8'h5a);
    check("level freq", {lvl, 1'b0, rfs}, 8'hef);
    check("ref off", {2'h0, ref_run}, 8'h00);
    $display("row test done");
    wq = {8'hff, 8'he7};
    u_host.write_block(8'hd2, 8'h03, wq, nack);
    for (int i = 0; i < 4; i++) begin
      req_n <= rq[i];
      repeat (4) @(posedge ref_clk);
      check("gated run", {gfx_run, ref_run}, gate_exp[i]);
    end
    $display("request gating test done");
    wq = {8'h00};
    u_host.write_block(8'hd4, 8'h01, wq, nack);
    check("foreign nack", {7'h00, nack}, 8'h01);
    u_host.read_block(8'h01, 1, q);
    check("untouched", q[1], 8'h5a);
    $display("address test done");
    give_verdict();
  end
endmodule : clock_gen_control_bank_test
